// ---- hdl/pmx_pkg.sv ----
// package of constants and types for the pad multiplexer
package pmx_pkg;

  // ---------------------------------------------------------------
  // pad set and mux codes
  // ---------------------------------------------------------------
  localparam int PMX_N_PADS = 8;
  localparam int PMX_N_ADC_PADS = 4;
  localparam int PMX_CODE_W = 4;
  localparam int PMX_N_CODES = 16;
  localparam int PMX_PAD_W = 3;
  localparam logic [PMX_CODE_W-1:0] PMX_CODE_GPIO = 4'h0;
  localparam logic [PMX_CODE_W-1:0] PMX_CODE_CAMERA = 4'h4;
  localparam logic [PMX_CODE_W-1:0] PMX_CODE_SERIAL1 = 4'h6;
  localparam logic [PMX_CODE_W-1:0] PMX_CODE_RESET = PMX_CODE_GPIO;
  // pad index 0 is the first analog-capable pad, index 7 the last pad
  localparam logic [PMX_PAD_W-1:0] PMX_PAD_CAMERA_DATA_BIT7 = 3'h1;
  localparam logic [PMX_PAD_W-1:0] PMX_PAD_CAMERA_DATA_BIT6 = 3'h2;

  // ---------------------------------------------------------------
  // legal codes per pad, one bit per code
  // ---------------------------------------------------------------
  localparam logic [PMX_N_PADS-1:0][PMX_N_CODES-1:0] PMX_LEGAL = {
    16'h10c9, 16'h10c1, 16'h2c09, 16'h00f9,
    16'h00d1, 16'h0051, 16'h0051, 16'h00c9
  };

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PMX_CLK_PERIOD_NS = 100;
  localparam int PMX_RTC_SENSE_TIME_NS = 1000;
  localparam int PMX_RTC_SENSE_CYC =
    (PMX_RTC_SENSE_TIME_NS + PMX_CLK_PERIOD_NS - 1) / PMX_CLK_PERIOD_NS;
  localparam int PMX_SENSE_W = 16;
  // edges after release before the filtered crystal pad level is valid
  localparam int PMX_SYNC_SETTLE_CYC = 4;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PMX_ACTIVE,
    PMX_SLEEP,
    PMX_HIB
  } pmx_pwr_t;

  typedef enum logic [1:0] {
    PMX_SENSE_WAIT,
    PMX_SENSE_DONE
  } pmx_sense_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
    logic pd;
  } pmx_pad_ctl_t;

  typedef struct packed {
    logic en;
    logic drive;
    logic level;
    logic pu;
    logic pd;
  } pmx_lp_cfg_t;

  localparam pmx_pad_ctl_t PMX_CTL_HIZ = '{out: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b0};

endpackage : pmx_pkg

// ---- hdl/pmx_pad_cell.sv ----
// per-pad selection of drive, enable and pulls
`timescale 1ns/100ps
module pmx_pad_cell
  import pmx_pkg::*;
(
  // power state and selection
  input wire pmx_pwr_t pwr,
  input wire logic [PMX_CODE_W-1:0] code,
  input wire logic analog_sel,
  input wire pmx_lp_cfg_t lp_cfg,
  // function candidates
  input wire logic [PMX_N_CODES-1:0] func_out,
  input wire logic [PMX_N_CODES-1:0] func_oe,
  // resulting pad control
  output pmx_pad_ctl_t ctl
);

  wire pmx_pad_ctl_t active_ctl;
  wire pmx_pad_ctl_t lp_ctl;

  // analog selection takes the digital driver off the pad
  assign active_ctl = analog_sel ? PMX_CTL_HIZ :
    pmx_pad_ctl_t'{out: func_out[code], oe: func_oe[code], pu: 1'b0, pd: 1'b0};
  // low power: hi-z unless software programs input, pull or drive
  assign lp_ctl = lp_cfg.en ?
    pmx_pad_ctl_t'{out: lp_cfg.level, oe: lp_cfg.drive, pu: lp_cfg.pu, pd: lp_cfg.pd} :
    PMX_CTL_HIZ;
  assign ctl = (pwr == PMX_ACTIVE) ? active_ctl : lp_ctl;

endmodule : pmx_pad_cell

// ---- hdl/pmx_top.sv ----
// pad multiplexer with low-power pad states, strap, clock sense and antenna pads
`timescale 1ns/100ps
module pmx_top
  import pmx_pkg::*;
#(
  parameter int RTC_SENSE_CYC = PMX_RTC_SENSE_CYC
) (
  // clock and chip reset
  input wire logic clk,
  input wire logic arst_n,
  // power state
  input wire pmx_pwr_t pwr,
  // mux code writes
  input wire logic mux_wr_en,
  input wire logic [PMX_PAD_W-1:0] mux_wr_pad,
  input wire logic [PMX_CODE_W-1:0] mux_wr_code,
  output logic mux_wr_reject,
  output logic [PMX_N_PADS-1:0][PMX_CODE_W-1:0] mux_code,
  // analog selection per converter pad
  input wire logic [PMX_N_ADC_PADS-1:0] analog_sel,
  output logic [PMX_N_ADC_PADS-1:0] converter_route,
  // low-power overrides per pad
  input wire pmx_lp_cfg_t [PMX_N_PADS-1:0] lp_cfg,
  // functions to pads
  input wire logic [PMX_N_PADS-1:0][PMX_N_CODES-1:0] func_out,
  input wire logic [PMX_N_PADS-1:0][PMX_N_CODES-1:0] func_oe,
  output logic [PMX_N_PADS-1:0] func_in,
  // muxed pads
  input wire logic [PMX_N_PADS-1:0] pad_in,
  output logic [PMX_N_PADS-1:0] pad_out,
  output logic [PMX_N_PADS-1:0] pad_oe,
  output logic [PMX_N_PADS-1:0] pad_pu,
  output logic [PMX_N_PADS-1:0] pad_pd,
  // strap pad for operation mode bit 2
  output logic op_mode_strap_bit2_out,
  output logic op_mode_strap_bit2_oe,
  output logic op_mode_strap_bit2_pd,
  // clock crystal output pad and sense result
  input wire logic rtc_pad_in,
  input wire logic rtc_gpio_out,
  input wire logic rtc_gpio_oe,
  output logic rtc_pad_out,
  output logic rtc_pad_oe,
  output logic ext_rtc_clk_sel,
  output logic rtc_sense_done,
  // antenna select
  input wire logic antenna_choice,
  output logic antenna_select_a,
  output logic antenna_select_b
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // a shorter window would latch the filter's reset level, not the pad
  if (RTC_SENSE_CYC <= PMX_SYNC_SETTLE_CYC || RTC_SENSE_CYC >= (1 << PMX_SENSE_W)) begin : g_bad_sense
    $error("pmx_top: RTC_SENSE_CYC out of range");
  end

  // ---------------------------------------------------------------
  // mux code registers
  // ---------------------------------------------------------------
  wire logic wr_legal;
  wire logic wr_take;
  // only documented codes of the addressed pad are accepted
  assign wr_legal = PMX_LEGAL[mux_wr_pad][mux_wr_code];
  assign wr_take = mux_wr_en && wr_legal;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_code <= {PMX_N_PADS{PMX_CODE_RESET}};
      mux_wr_reject <= 1'b0;
    end else begin
      if (wr_take) begin
        mux_code[mux_wr_pad] <= mux_wr_code;
      end
      mux_wr_reject <= mux_wr_en && !wr_legal;
    end
  end

  // ---------------------------------------------------------------
  // per-pad selection, synchronisers and output flops
  // ---------------------------------------------------------------
  for (genvar i = 0; i < PMX_N_PADS; i++) begin : g_pad
    wire pmx_pad_ctl_t next_ctl;
    wire logic pad_analog;
    logic [2:0] sync;

    if (i < PMX_N_ADC_PADS) begin : g_adc
      assign pad_analog = analog_sel[i];
    end else begin : g_dig
      assign pad_analog = 1'b0;
    end

    pmx_pad_cell u_cell (
      .pwr(pwr),
      .code(mux_code[i]),
      .analog_sel(pad_analog),
      .lp_cfg(lp_cfg[i]),
      .func_out(func_out[i]),
      .func_oe(func_oe[i]),
      .ctl(next_ctl)
    );

    // async reset holds the pad hi-z for the whole reset
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pad_out[i] <= PMX_CTL_HIZ.out;
        pad_oe[i] <= PMX_CTL_HIZ.oe;
        pad_pu[i] <= PMX_CTL_HIZ.pu;
        pad_pd[i] <= PMX_CTL_HIZ.pd;
      end else begin
        pad_out[i] <= next_ctl.out;
        pad_oe[i] <= next_ctl.oe;
        pad_pu[i] <= next_ctl.pu;
        pad_pd[i] <= next_ctl.pd;
      end
    end

    // input reaches the function only when the last two stages agree
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sync <= 3'h0;
        func_in[i] <= 1'b0;
      end else begin
        sync <= {sync[1:0], pad_in[i]};
        if (sync[1] == sync[2]) begin
          func_in[i] <= sync[2];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // converter routing
  // ---------------------------------------------------------------
  wire logic [PMX_N_ADC_PADS-1:0] next_route;
  // routing holds only while active; pad goes to converter instead of digital
  assign next_route = (pwr == PMX_ACTIVE) ? analog_sel : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_route <= '0;
    end else begin
      converter_route <= next_route;
    end
  end

  // ---------------------------------------------------------------
  // operation mode strap pad
  // ---------------------------------------------------------------
  wire logic strap_hib;
  assign strap_hib = (pwr == PMX_HIB);

  // the strap drives high outside hibernate; in hibernate it is released with its pull-down on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_mode_strap_bit2_out <= 1'b0;
      op_mode_strap_bit2_oe <= 1'b0;
      op_mode_strap_bit2_pd <= 1'b0;
    end else begin
      op_mode_strap_bit2_out <= !strap_hib;
      op_mode_strap_bit2_oe <= !strap_hib;
      op_mode_strap_bit2_pd <= strap_hib;
    end
  end

  // ---------------------------------------------------------------
  // clock source sensing
  // ---------------------------------------------------------------
  logic [2:0] rtc_sync;
  logic rtc_level;
  logic [PMX_SENSE_W-1:0] sense_cnt;
  pmx_sense_t sense_state;
  wire logic sense_end;
  wire logic rtc_released;

  assign sense_end = (sense_cnt == PMX_SENSE_W'(RTC_SENSE_CYC - 1));
  // the pad is free for digital use only once an external clock was found
  assign rtc_released = (sense_state == PMX_SENSE_DONE) && ext_rtc_clk_sel;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rtc_sync <= 3'h0;
      rtc_level <= 1'b0;
    end else begin
      rtc_sync <= {rtc_sync[1:0], rtc_pad_in};
      if (rtc_sync[1] == rtc_sync[2]) begin
        rtc_level <= rtc_sync[2];
      end
    end
  end

  // level is sampled after release, so the flop never loads a port under reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sense_state <= PMX_SENSE_WAIT;
      sense_cnt <= '0;
      ext_rtc_clk_sel <= 1'b0;
      rtc_sense_done <= 1'b0;
    end else begin
      case (sense_state)
        PMX_SENSE_WAIT: begin
          sense_cnt <= sense_cnt + PMX_SENSE_W'(1);
          if (sense_end) begin
            ext_rtc_clk_sel <= rtc_level;
            rtc_sense_done <= 1'b1;
            sense_state <= PMX_SENSE_DONE;
          end
        end
        PMX_SENSE_DONE: begin
          sense_state <= PMX_SENSE_DONE;
        end
        default: begin
          sense_state <= PMX_SENSE_WAIT;
        end
      endcase
    end
  end

  // released pad drives only; an input use could fake the pull-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rtc_pad_out <= 1'b0;
      rtc_pad_oe <= 1'b0;
    end else begin
      rtc_pad_out <= rtc_released && rtc_gpio_out;
      rtc_pad_oe <= rtc_released && rtc_gpio_oe && (pwr == PMX_ACTIVE);
    end
  end

  // ---------------------------------------------------------------
  // antenna select
  // ---------------------------------------------------------------
  // no mux code reaches these pads, they only follow the antenna choice
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      antenna_select_a <= 1'b1;
      antenna_select_b <= 1'b0;
    end else begin
      antenna_select_a <= !antenna_choice;
      antenna_select_b <= antenna_choice;
    end
  end

endmodule : pmx_top

// ---- testbench/pmx_top_properties.sv ----
// port checker for the pad multiplexer
`timescale 1ns/100ps
module pmx_top_chk
  import pmx_pkg::*;
#(
  parameter int RTC_SENSE_CYC = PMX_RTC_SENSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // controls
  input wire pmx_pwr_t pwr,
  input wire logic mux_wr_en,
  input wire logic [PMX_PAD_W-1:0] mux_wr_pad,
  input wire logic [PMX_CODE_W-1:0] mux_wr_code,
  input wire logic [PMX_N_ADC_PADS-1:0] analog_sel,
  input wire pmx_lp_cfg_t [PMX_N_PADS-1:0] lp_cfg,
  input wire logic antenna_choice,
  // results
  input wire logic mux_wr_reject,
  input wire logic [PMX_N_PADS-1:0][PMX_CODE_W-1:0] mux_code,
  input wire logic [PMX_N_ADC_PADS-1:0] converter_route,
  input wire logic [PMX_N_PADS-1:0] pad_oe,
  input wire logic [PMX_N_PADS-1:0] pad_pu,
  input wire logic op_mode_strap_bit2_out,
  input wire logic op_mode_strap_bit2_oe,
  input wire logic op_mode_strap_bit2_pd,
  input wire logic rtc_sense_done,
  input wire logic antenna_select_a,
  input wire logic antenna_select_b
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic [7:0] cnt;
  logic [PMX_N_PADS-1:0] lp_drv, lp_pu;
  always_comb begin
    for (int i = 0; i < PMX_N_PADS; i++) begin
      lp_drv[i] = lp_cfg[i].en & lp_cfg[i].drive;
      lp_pu[i] = lp_cfg[i].en & lp_cfg[i].pu;
    end
  end
  // edges since release, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt <= 8'h00;
    else if (cnt != 8'hff) cnt <= cnt + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_reset_hiz: assert property (disable iff (1'b0)
    !arst_n |-> pad_oe == '0 && mux_code == '0) else $error("pads or codes not reset");
  chk_ant_follow: assert property ($past(arst_n) |->
    antenna_select_b == $past(antenna_choice) && antenna_select_a != antenna_select_b)
    else $error("antenna pads wrong");
  chk_strap_state: assert property ($past(arst_n) |->
    {op_mode_strap_bit2_out, op_mode_strap_bit2_oe, op_mode_strap_bit2_pd}
    == ($past(pwr) == PMX_HIB ? 3'h1 : 3'h6)) else $error("strap pad state wrong");
  chk_lp_state: assert property ($past(arst_n) && $past(pwr) != PMX_ACTIVE |->
    pad_oe == $past(lp_drv) && pad_pu == $past(lp_pu)) else $error("low-power pad wrong");
  chk_route_sel: assert property ($past(arst_n) |-> converter_route ==
    ($past(pwr) == PMX_ACTIVE ? $past(analog_sel) : 4'h0)) else $error("route wrong");
  chk_analog_hiz: assert property ($past(arst_n) && $past(pwr) == PMX_ACTIVE |->
    (pad_oe[3:0] & $past(analog_sel)) == 4'h0) else $error("analog pad driven");
  chk_write_taken: assert property (mux_wr_en && PMX_LEGAL[mux_wr_pad][mux_wr_code]
    |=> mux_code[$past(mux_wr_pad)] == $past(mux_wr_code)) else $error("write lost");
  chk_write_refused: assert property (mux_wr_en && !PMX_LEGAL[mux_wr_pad][mux_wr_code]
    |=> mux_wr_reject && $stable(mux_code)) else $error("illegal write taken");
  chk_sense_time: assert property (rtc_sense_done == (cnt >= RTC_SENSE_CYC))
    else $error("clock sense at wrong edge");
  cover property (mux_wr_en && !PMX_LEGAL[mux_wr_pad][mux_wr_code]);
  cover property (pwr == PMX_HIB);
  cover property ($rose(rtc_sense_done));
endmodule : pmx_top_chk

bind pmx_top pmx_top_chk #(.RTC_SENSE_CYC(RTC_SENSE_CYC)) u_chk (
  .clk(clk),
  .arst_n(arst_n),
  .pwr(pwr),
  .mux_wr_en(mux_wr_en),
  .mux_wr_pad(mux_wr_pad),
  .mux_wr_code(mux_wr_code),
  .analog_sel(analog_sel),
  .lp_cfg(lp_cfg),
  .antenna_choice(antenna_choice),
  .mux_wr_reject(mux_wr_reject),
  .mux_code(mux_code),
  .converter_route(converter_route),
  .pad_oe(pad_oe),
  .pad_pu(pad_pu),
  .op_mode_strap_bit2_out(op_mode_strap_bit2_out),
  .op_mode_strap_bit2_oe(op_mode_strap_bit2_oe),
  .op_mode_strap_bit2_pd(op_mode_strap_bit2_pd),
  .rtc_sense_done(rtc_sense_done),
  .antenna_select_a(antenna_select_a),
  .antenna_select_b(antenna_select_b)
);

// ---- testbench/pmx_board.sv ----
// board model: pad pulls, crystal pad pull-up, floating lines
`timescale 1ns/100ps
module pmx_board
  import pmx_pkg::*;
(
  // clock for the floating pattern
  input wire logic clk,
  // pad controls from the device
  input wire logic [PMX_N_PADS-1:0] pad_out,
  input wire logic [PMX_N_PADS-1:0] pad_oe,
  input wire logic [PMX_N_PADS-1:0] pad_pu,
  input wire logic [PMX_N_PADS-1:0] pad_pd,
  input wire logic rtc_pad_out,
  input wire logic rtc_pad_oe,
  // levels seen back at the pads
  output logic [PMX_N_PADS-1:0] pad_in,
  output logic rtc_pad_in
);
  logic flip = 1'b0;
  always @(posedge clk) flip <= ~flip;
  // a floating pad toggles so a stale level never looks valid
  always_comb begin
    for (int i = 0; i < PMX_N_PADS; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (pad_pu[i] | pad_pd[i]) pad_in[i] = pad_pu[i];
      else pad_in[i] = flip ^ i[0];
    end
  end
  // strap pad is never driven from the board
  // pull-up fitted: square-wave clock option, pad used as output only
  assign rtc_pad_in = rtc_pad_oe ? rtc_pad_out : 1'b1;
endmodule : pmx_board

// ---- testbench/pmx_top_bench.sv ----
// self-checking bench for the pad multiplexer
`timescale 1ns/100ps
module pmx_top_bench;
  import pmx_pkg::*;
  localparam int SENSE = 6;
  logic clk = 1'b0;
  logic arst_n = 1'b1;
  pmx_pwr_t pwr = PMX_ACTIVE;
  logic mux_wr_en = 1'b0;
  logic [PMX_PAD_W-1:0] mux_wr_pad = 3'h0;
  logic [PMX_CODE_W-1:0] mux_wr_code = 4'h0;
  logic [PMX_N_ADC_PADS-1:0] analog_sel = 4'h0;
  pmx_lp_cfg_t [PMX_N_PADS-1:0] lp_cfg = '0;
  logic [PMX_N_PADS-1:0][PMX_N_CODES-1:0] func_out = {PMX_N_PADS{16'h0011}};
  logic [PMX_N_PADS-1:0][PMX_N_CODES-1:0] func_oe = {PMX_N_PADS{16'h0041}};
  logic rtc_gpio_out = 1'b0, rtc_gpio_oe = 1'b0, antenna_choice = 1'b0;
  logic mux_wr_reject, rtc_pad_in, rtc_pad_out, rtc_pad_oe, ext_rtc_clk_sel, rtc_sense_done;
  logic antenna_select_a, antenna_select_b;
  logic op_mode_strap_bit2_out, op_mode_strap_bit2_oe, op_mode_strap_bit2_pd;
  logic [PMX_N_PADS-1:0][PMX_CODE_W-1:0] mux_code;
  logic [PMX_N_ADC_PADS-1:0] converter_route;
  logic [PMX_N_PADS-1:0] func_in, pad_in, pad_out, pad_oe, pad_pu, pad_pd;
  int codes[3] = '{4, 6, 0};
  int miscompares = 0;
  int n_checks = 0;

  pmx_top #(.RTC_SENSE_CYC(SENSE)) u_dut (
    .clk(clk),
    .arst_n(arst_n),
    .pwr(pwr),
    .mux_wr_en(mux_wr_en),
    .mux_wr_pad(mux_wr_pad),
    .mux_wr_code(mux_wr_code),
    .mux_wr_reject(mux_wr_reject),
    .mux_code(mux_code),
    .analog_sel(analog_sel),
    .converter_route(converter_route),
    .lp_cfg(lp_cfg),
    .func_out(func_out),
    .func_oe(func_oe),
    .func_in(func_in),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pu(pad_pu),
    .pad_pd(pad_pd),
    .op_mode_strap_bit2_out(op_mode_strap_bit2_out),
    .op_mode_strap_bit2_oe(op_mode_strap_bit2_oe),
    .op_mode_strap_bit2_pd(op_mode_strap_bit2_pd),
    .rtc_pad_in(rtc_pad_in),
    .rtc_gpio_out(rtc_gpio_out),
    .rtc_gpio_oe(rtc_gpio_oe),
    .rtc_pad_out(rtc_pad_out),
    .rtc_pad_oe(rtc_pad_oe),
    .ext_rtc_clk_sel(ext_rtc_clk_sel),
    .rtc_sense_done(rtc_sense_done),
    .antenna_choice(antenna_choice),
    .antenna_select_a(antenna_select_a),
    .antenna_select_b(antenna_select_b)
  );
  pmx_board u_board (
    .clk(clk),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pu(pad_pu),
    .pad_pd(pad_pd),
    .rtc_pad_out(rtc_pad_out),
    .rtc_pad_oe(rtc_pad_oe),
    .pad_in(pad_in),
    .rtc_pad_in(rtc_pad_in)
  );

  initial forever #50 clk = ~clk;

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic pad_is(input int p, input logic [3:0] exp);
    cmp("pad", 32'(exp), 32'({pad_out[p], pad_oe[p], pad_pu[p], pad_pd[p]}));
  endtask : pad_is

  // reject stands for exactly the one cycle after the write
  task automatic wr(input int pad, input int code, input logic exp_rej);
    logic [1:0] seen;
    @(negedge clk);
    mux_wr_en = 1'b1;
    mux_wr_pad = PMX_PAD_W'(pad);
    mux_wr_code = PMX_CODE_W'(code);
    @(negedge clk);
    mux_wr_en = 1'b0;
    seen[0] = mux_wr_reject;
    @(negedge clk);
    seen[1] = mux_wr_reject;
    cmp("reject", 32'({1'b0, exp_rej}), 32'(seen));
  endtask : wr

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  initial begin
    #100000;
    miscompares++;
    final_report();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    // a real falling edge, so the reset branch runs before the first clock
    #1 arst_n = 1'b0;
    tick(20);
    cmp("oe", 32'h0, 32'(pad_oe));
    cmp("ant", 32'h2, 32'({antenna_select_a, antenna_select_b}));
    arst_n = 1'b1;
    tick(SENSE + 1);
    cmp("sense", 32'h3, 32'({rtc_sense_done, ext_rtc_clk_sel}));
    cmp("strap", 32'h6, 32'({op_mode_strap_bit2_out, op_mode_strap_bit2_oe,
      op_mode_strap_bit2_pd}));
    cmp("code", 32'h0, mux_code);
    for (int p = 0; p < PMX_N_PADS; p++) pad_is(p, 4'hc);
    cmp("func_in", 32'hff, 32'(func_in));
    for (int p = 1; p < 3; p++) begin
      foreach (codes[k]) begin
        wr(p, codes[k], 1'b0);
        cmp("code", 32'(codes[k]), 32'(mux_code[p]));
        pad_is(p, {func_out[p][codes[k]], func_oe[p][codes[k]], 2'h0});
      end
    end
    wr(1, 4, 1'b0);
    wr(1, 5, 1'b1);
    cmp("code", 32'h4, 32'(mux_code[1]));
    analog_sel = 4'h2;
    tick(2);
    cmp("route", 32'h2, 32'(converter_route));
    cmp("oe", 32'h0, 32'(pad_oe[1]));
    analog_sel = 4'h0;
    antenna_choice = 1'b1;
    tick(2);
    pad_is(1, 4'h8);
    cmp("ant", 32'h1, 32'({antenna_select_a, antenna_select_b}));
    pwr = PMX_SLEEP;
    lp_cfg[5] = 5'h11;
    lp_cfg[2] = 5'h1c;
    tick(2);
    cmp("oe", 32'h4, 32'(pad_oe));
    cmp("pd", 32'h20, 32'(pad_pd));
    pad_is(2, 4'hc);
    cmp("route", 32'h0, 32'(converter_route));
    pwr = PMX_HIB;
    lp_cfg = '0;
    tick(2);
    cmp("hiz", 32'h0, 32'({pad_oe, pad_pu, pad_pd}));
    cmp("strap", 32'h1, 32'({op_mode_strap_bit2_out, op_mode_strap_bit2_oe,
      op_mode_strap_bit2_pd}));
    lp_cfg[7] = 5'h12;
    tick(2);
    pad_is(7, 4'h2);
    pwr = PMX_ACTIVE;
    lp_cfg = '0;
    rtc_gpio_oe = 1'b1;
    tick(2);
    cmp("rtc", 32'h1, 32'({rtc_pad_out, rtc_pad_oe}));
    arst_n = 1'b0;
    tick(1);
    cmp("code", 32'h0, mux_code);
    cmp("oe", 32'h0, 32'({pad_oe, rtc_pad_oe, op_mode_strap_bit2_oe}));
    arst_n = 1'b1;
    tick(2);
    pad_is(1, 4'hc);
    final_report();
  end
endmodule : pmx_top_bench
